// >>> design/ccr_pkg.sv
// Constants and types for the channel calibration register bank
// Function
// - Address 0xa holds offset bits 23..8
// - Address 0xb: offset low byte, reserved zero
// - Address 0xc holds gain bits, resets 0x8000
// - Address 0xd: gain low byte, reserved zero
// - Offset high reads zero after reset
// - Address 0xe channel config resets zero
package ccr_pkg;
  localparam int          CCR_AW         = 4;
  localparam int          CCR_DW         = 16;
  localparam int          CCR_CW         = 24;
  localparam int          CCR_BYTE       = 8;
  localparam logic [3:0]  CCR_OFS_HIGH   = 4'ha;
  localparam logic [3:0]  CCR_OFS_LOW    = 4'hb;
  localparam logic [3:0]  CCR_GAIN_HIGH  = 4'hc;
  localparam logic [3:0]  CCR_GAIN_LOW   = 4'hd;
  localparam logic [3:0]  CCR_SECOND_CHANNEL_CONFIG    = 4'he;
  localparam logic [15:0] CCR_OFS_HIGH_RST  = 16'h0000;
  localparam logic [7:0]  CCR_LOW_BYTE_RST  = 8'h00;
  localparam logic [15:0] CCR_GAIN_HIGH_RST = 16'h8000;
  localparam logic [15:0] CCR_SECOND_CHANNEL_CONFIG_RST   = 16'h0000;
  localparam logic [7:0]  CCR_RSVD_BYTE     = 8'h00;
  localparam logic [15:0] CCR_UNMAPPED      = 16'h0000;

  typedef struct packed {
    logic [3:0]  addr;
    logic [15:0] wdata;
    logic        wr;
    logic        rd;
  } ccr_req_s;

  typedef struct packed {
    logic [15:0] offset_word_upper;
    logic [7:0]  offset_word_lower;
    logic [15:0] gain_word_upper;
    logic [7:0]  gain_word_lower;
    logic [15:0] second_channel_config;
    logic [15:0] rdata;
  } ccr_state_s;
endpackage

// >>> design/ccr_low_reg.sv
// Least-significant calibration register: upper byte stored, low byte reserved
`timescale 1ns/100ps
module ccr_low_reg
  import ccr_pkg::*;
(
  input  wire logic       ref_clk_in,
  input  wire logic       rst_n_in,
  input  wire logic       wr_in,
  input  wire logic [15:0] wdata_in,
  output logic      [7:0] byte_out,
  output logic      [15:0] view_out
);
  logic [7:0] byte_reg;
  logic [7:0] byte_next;

  always_comb begin
    byte_next = byte_reg;
    if (wr_in) begin
      byte_next = wdata_in[CCR_DW-1:CCR_BYTE]; // Low byte dropped
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      byte_reg <= CCR_LOW_BYTE_RST;
    end else begin
      byte_reg <= byte_next;
    end
  end

  assign byte_out = byte_reg;
  assign view_out = {byte_reg, CCR_RSVD_BYTE};

  a_low_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_in |=> byte_reg == $past(wdata_in[15:8]))
    else $error("low register write not stored");
  a_rsvd_zero: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    view_out[7:0] == 8'h00)
    else $error("reserved byte not zero");
endmodule

// >>> design/ccr_regs.sv
// Channel calibration register bank with plain register port
//
// Implementation choice: the strobed register port.
`timescale 1ns/100ps
module ccr_regs
  import ccr_pkg::*;
(
  input  wire logic        ref_clk_in,
  input  wire logic        rst_n_in,
  input  wire logic [3:0]  addr_in,
  input  wire logic [15:0] wdata_in,
  input  wire logic        wr_in,
  input  wire logic        rd_in,
  output logic      [15:0] rdata_out,
  output logic      [23:0] offset_word_out,
  output logic      [23:0] gain_word_out,
  output logic      [15:0] second_channel_config_out
);
  ccr_req_s   req;
  ccr_state_s st_reg;
  ccr_state_s st_next;
  logic [7:0]  ofs_lo;
  logic [7:0]  gain_lo;
  logic [15:0] ofs_lo_view;
  logic [15:0] gain_lo_view;
  logic        ofs_lo_wr;
  logic        gain_lo_wr;

  assign req = '{addr: addr_in, wdata: wdata_in, wr: wr_in, rd: rd_in};
  assign ofs_lo_wr  = req.wr && (req.addr == CCR_OFS_LOW);
  assign gain_lo_wr = req.wr && (req.addr == CCR_GAIN_LOW);

  ccr_low_reg u_ofs_low (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .wr_in      (ofs_lo_wr),
    .wdata_in   (req.wdata),
    .byte_out   (ofs_lo),
    .view_out   (ofs_lo_view)
  );

  ccr_low_reg u_gain_low (
    .ref_clk_in (ref_clk_in),
    .rst_n_in   (rst_n_in),
    .wr_in      (gain_lo_wr),
    .wdata_in   (req.wdata),
    .byte_out   (gain_lo),
    .view_out   (gain_lo_view)
  );

  always_comb begin
    st_next = st_reg;
    st_next.offset_word_lower = ofs_lo;
    st_next.gain_word_lower   = gain_lo;
    if (req.wr) begin
      unique case (req.addr)
        CCR_OFS_HIGH:  st_next.offset_word_upper = req.wdata;
        CCR_GAIN_HIGH: st_next.gain_word_upper = req.wdata;
        CCR_SECOND_CHANNEL_CONFIG:   st_next.second_channel_config = req.wdata;
        default: ;
      endcase
    end
    st_next.rdata = CCR_UNMAPPED;
    if (req.rd) begin
      unique case (req.addr)
        CCR_OFS_HIGH:  st_next.rdata = st_reg.offset_word_upper;
        CCR_OFS_LOW:   st_next.rdata = ofs_lo_view;
        CCR_GAIN_HIGH: st_next.rdata = st_reg.gain_word_upper;
        CCR_GAIN_LOW:  st_next.rdata = gain_lo_view;
        CCR_SECOND_CHANNEL_CONFIG:   st_next.rdata = st_reg.second_channel_config;
        default:       st_next.rdata = CCR_UNMAPPED;
      endcase
    end
  end

  always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      st_reg.offset_word_upper     <= CCR_OFS_HIGH_RST;
      st_reg.offset_word_lower     <= CCR_LOW_BYTE_RST;
      st_reg.gain_word_upper       <= CCR_GAIN_HIGH_RST;
      st_reg.gain_word_lower       <= CCR_LOW_BYTE_RST;
      st_reg.second_channel_config <= CCR_SECOND_CHANNEL_CONFIG_RST;
      st_reg.rdata                 <= CCR_UNMAPPED;
    end else begin
      st_reg <= st_next;
    end
  end

  // Lower bytes mirror the leaf registers one cycle late; outputs use leaf copies
  assign rdata_out                 = st_reg.rdata;
  assign offset_word_out           = {st_reg.offset_word_upper, ofs_lo};
  assign gain_word_out             = {st_reg.gain_word_upper, gain_lo};
  assign second_channel_config_out = st_reg.second_channel_config;

  sequence s_write_to(logic [3:0] a);
    wr_in && addr_in == a;
  endsequence

  sequence s_read_of(logic [3:0] a);
    rd_in && !wr_in && addr_in == a;
  endsequence

  // Write then read with no gap; the read must already see the new value
  sequence s_write_read(logic [3:0] a);
    s_write_to(a) ##1 s_read_of(a);
  endsequence

  a_ofs_high_rw: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_write_read(CCR_OFS_HIGH)
      |=> rdata_out == $past(wdata_in, 2))
    else $error("offset high readback wrong");
  a_ofs_low_rw: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_write_read(CCR_OFS_LOW)
      |=> rdata_out == {$past(wdata_in[15:8], 2), CCR_RSVD_BYTE})
    else $error("offset low write then read wrong");
  a_gain_high_rw: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_write_read(CCR_GAIN_HIGH)
      |=> rdata_out == $past(wdata_in, 2))
    else $error("gain high write then read wrong");
  a_gain_low_rw: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_write_read(CCR_GAIN_LOW)
      |=> rdata_out == {$past(wdata_in[15:8], 2), CCR_RSVD_BYTE})
    else $error("gain low write then read wrong");
  a_cfg_rw: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_write_read(CCR_SECOND_CHANNEL_CONFIG)
      |=> rdata_out == $past(wdata_in, 2))
    else $error("channel config write then read wrong");

  a_ofs_low_read: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == CCR_OFS_LOW |=> rdata_out == {$past(ofs_lo), 8'h00})
    else $error("offset low readback wrong");
  a_gain_high_rd: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == CCR_GAIN_HIGH |=> rdata_out == $past(gain_word_out[23:8]))
    else $error("gain high readback wrong");
  a_gain_low_rd: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_in && addr_in == CCR_GAIN_LOW |=> rdata_out[7:0] == 8'h00
      && rdata_out[15:8] == $past(gain_lo))
    else $error("gain low readback wrong");
  a_rdata_idle: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !rd_in |=> rdata_out == 16'h0000)
    else $error("read data not zero when idle");

  // Reset values must show on the first edge after release
  a_ofs_rst_val: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in)
      |-> offset_word_out[23:8] == CCR_OFS_HIGH_RST)
    else $error("offset high reset value wrong");
  a_gain_rst_val: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in)
      |-> gain_word_out == {CCR_GAIN_HIGH_RST, CCR_LOW_BYTE_RST})
    else $error("gain reset value wrong");
  a_low_rst_val: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in)
      |-> offset_word_out[7:0] == CCR_LOW_BYTE_RST
        && gain_word_out[7:0] == CCR_LOW_BYTE_RST)
    else $error("low byte reset value wrong");
  a_cfg_rst_val: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in)
      |-> second_channel_config_out == CCR_SECOND_CHANNEL_CONFIG_RST)
    else $error("channel config reset value wrong");
  a_rdata_rst_val: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    $rose(rst_n_in)
      |-> rdata_out == CCR_UNMAPPED)
    else $error("read data not zero after reset");

  // Words change only when their own address is written
  a_ofs_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !(wr_in && addr_in == CCR_OFS_HIGH) |=> $stable(offset_word_out[23:8]))
    else $error("offset high changed without write");
  a_gain_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !(wr_in && addr_in == CCR_GAIN_HIGH)
      |=> $stable(gain_word_out[23:8]))
    else $error("gain high changed without write");
  a_ofs_low_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !(wr_in && addr_in == CCR_OFS_LOW)
      |=> $stable(offset_word_out[7:0]))
    else $error("offset low changed without write");
  a_gain_low_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !(wr_in && addr_in == CCR_GAIN_LOW)
      |=> $stable(gain_word_out[7:0]))
    else $error("gain low changed without write");
  a_cfg_hold: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    !(wr_in && addr_in == CCR_SECOND_CHANNEL_CONFIG)
      |=> $stable(second_channel_config_out))
    else $error("channel config changed without write");

  a_ofs_high_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_write_to(CCR_OFS_HIGH)
      |=> offset_word_out[23:8] == $past(wdata_in))
    else $error("offset high write lost");
  a_ofs_low_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_write_to(CCR_OFS_LOW)
      |=> offset_word_out[7:0] == $past(wdata_in[15:8]))
    else $error("offset low write lost");
  a_gain_low_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_write_to(CCR_GAIN_LOW)
      |=> gain_word_out[7:0] == $past(wdata_in[15:8]))
    else $error("gain low write lost");
  a_cfg_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_write_to(CCR_SECOND_CHANNEL_CONFIG) |=> second_channel_config_out == $past(wdata_in))
    else $error("channel config write lost");
  a_gain_write: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_write_to(CCR_GAIN_HIGH) |=> gain_word_out[23:8] == $past(wdata_in))
    else $error("gain high write lost");

  // Mirror copies trail the leaf registers by one cycle
  a_ofs_mirror: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_write_to(CCR_OFS_LOW)
      |=> ##1 st_reg.offset_word_lower == $past(wdata_in[15:8], 2))
    else $error("offset low mirror wrong");
  a_gain_mirror: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    s_write_to(CCR_GAIN_LOW)
      |=> ##1 st_reg.gain_word_lower == $past(wdata_in[15:8], 2))
    else $error("gain low mirror wrong");

  // Unmapped writes and any read without a write must leave the words alone
  a_unmapped_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    wr_in && (addr_in < CCR_OFS_HIGH || addr_in > CCR_SECOND_CHANNEL_CONFIG)
      |=> $stable(offset_word_out) && $stable(gain_word_out)
        && $stable(second_channel_config_out))
    else $error("unmapped write changed a word");
  a_read_quiet: assert property (@(posedge ref_clk_in) disable iff (!rst_n_in)
    rd_in && !wr_in
      |=> $stable(offset_word_out) && $stable(gain_word_out)
        && $stable(second_channel_config_out))
    else $error("read changed a word");
endmodule

// >>> bench/ccr_regs_tb_top.sv
// Self-checking testbench for the channel calibration register bank
`timescale 1ns/100ps
module ccr_regs_tb_top import ccr_pkg::*;;
  logic        ref_clk_in = 1'b0;
  logic        rst_n_in = 1'b0;
  logic [3:0]  addr_in = 4'h0;
  logic [15:0] wdata_in = 16'h0000;
  logic        wr_in = 1'b0;
  logic        rd_in = 1'b0;
  logic [15:0] rdata_out;
  logic [23:0] offset_word_out;
  logic [23:0] gain_word_out;
  logic [15:0] second_channel_config_out;
  logic [15:0] rv;
  int          err_count = 0;
  int          compares = 0;
  always #12.5 ref_clk_in = ~ref_clk_in;
  ccr_regs i_dut (
    .ref_clk_in                (ref_clk_in),
    .rst_n_in                  (rst_n_in),
    .addr_in                   (addr_in),
    .wdata_in                  (wdata_in),
    .wr_in                     (wr_in),
    .rd_in                     (rd_in),
    .rdata_out                 (rdata_out),
    .offset_word_out           (offset_word_out),
    .gain_word_out             (gain_word_out),
    .second_channel_config_out (second_channel_config_out)
  );
  task automatic chk16(input logic [15:0] got, input logic [15:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t reg got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
    compares++;
    if (got !== exp) begin
      err_count++;
      $display("mismatch t=%0t word got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic wr_reg(input logic [3:0] a, input logic [15:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
  endtask
  // Data stands only in the cycle after the strobe, so sample mid-cycle
  task automatic rd_reg(input logic [3:0] a, output logic [15:0] d);
    @(posedge ref_clk_in);
    addr_in <= a;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    @(negedge ref_clk_in);
    d = rdata_out;
  endtask
  task automatic wr_rd(input logic [3:0] a, input logic [15:0] d, output logic [15:0] q);
    @(posedge ref_clk_in);
    addr_in <= a;
    wdata_in <= d;
    wr_in <= 1'b1;
    @(posedge ref_clk_in);
    wr_in <= 1'b0;
    rd_in <= 1'b1;
    @(posedge ref_clk_in);
    rd_in <= 1'b0;
    @(negedge ref_clk_in);
    q = rdata_out;
  endtask
  task automatic t_defaults;
    logic [15:0] exp [5];
    exp = '{16'h0000, 16'h0000, 16'h8000, 16'h0000, 16'h0000};
    for (int i = 0; i < 5; i++) begin
      rd_reg(4'ha + 4'(i), rv);
      chk16(rv, exp[i]);
    end
    chk24(offset_word_out, 24'h000000);
    chk24(gain_word_out, 24'h800000);
  endtask
  task automatic t_write_back;
    logic [15:0] wv [5];
    logic [15:0] ev [5];
    wv = '{16'h1234, 16'habff, 16'h5678, 16'hcd5a, 16'hbeef};
    ev = '{16'h1234, 16'hab00, 16'h5678, 16'hcd00, 16'hbeef};
    for (int i = 0; i < 5; i++) wr_reg(4'ha + 4'(i), wv[i]);
    for (int i = 0; i < 5; i++) begin
      rd_reg(4'ha + 4'(i), rv);
      chk16(rv, ev[i]);
    end
    chk24(offset_word_out, 24'h1234ab);
    chk24(gain_word_out, 24'h5678cd);
    chk16(second_channel_config_out, 16'hbeef);
    @(negedge ref_clk_in);
    chk16(rdata_out, 16'h0000);
  endtask
  // Unmapped places must neither store nor alias onto the bank
  task automatic t_unmapped;
    wr_reg(4'h3, 16'hffff);
    rd_reg(4'h3, rv);
    chk16(rv, CCR_UNMAPPED);
    rd_reg(4'hf, rv);
    chk16(rv, CCR_UNMAPPED);
    chk24(offset_word_out, 24'h1234ab);
    chk24(gain_word_out, 24'h5678cd);
    chk16(second_channel_config_out, 16'hbeef);
  endtask
  // Write then read with no gap must already see the new value
  task automatic t_back_to_back;
    logic [15:0] wv [5];
    logic [15:0] ev [5];
    wv = '{16'h9abc, 16'h7e11, 16'h4321, 16'h0f3c, 16'h5a5a};
    ev = '{16'h9abc, 16'h7e00, 16'h4321, 16'h0f00, 16'h5a5a};
    for (int i = 0; i < 5; i++) begin
      wr_rd(4'ha + 4'(i), wv[i], rv);
      chk16(rv, ev[i]);
    end
    chk24(offset_word_out, 24'h9abc7e);
    chk24(gain_word_out, 24'h43210f);
    chk16(second_channel_config_out, 16'h5a5a);
  endtask
  task automatic t_mid_reset;
    @(posedge ref_clk_in);
    rst_n_in <= 1'b0;
    @(negedge ref_clk_in);
    chk24(gain_word_out, 24'h800000);
    chk24(offset_word_out, 24'h000000);
    chk16(second_channel_config_out, 16'h0000);
    repeat (2) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    rd_reg(4'hd, rv);
    chk16(rv, 16'h0000);
    rd_reg(4'hc, rv);
    chk16(rv, 16'h8000);
  endtask
  task automatic test_done;
    $display("errors %0d compares %0d", err_count, compares);
    if (err_count == 0 && compares > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  initial begin
    repeat (5) @(posedge ref_clk_in);
    rst_n_in <= 1'b1;
    t_defaults;
    t_write_back;
    t_unmapped;
    t_back_to_back;
    t_mid_reset;
    test_done;
  end
  initial begin
    #20000;
    err_count++;
    test_done;
  end
endmodule
